/* core/odsm_defines.svh */
// Register map, field positions, reset values and codes
`ifndef ODSM_DEFINES_SVH
`define ODSM_DEFINES_SVH

`define ODSM_ADDR_CH7_CTRL   8'h2b
`define ODSM_ADDR_CH7_DIV    8'h2c
`define ODSM_ADDR_CMOS_CTRL  8'h2d
`define ODSM_ADDR_PATH_CTRL  8'h30

`define ODSM_RST_CH7_MUX     2'h0
`define ODSM_RST_CH7_DIV     8'h05
`define ODSM_RST_CMOS_CTRL   8'h0a
`define ODSM_RST_PATH_CTRL   2'h0
`define ODSM_ZERO8           8'h00
`define ODSM_RST_OE_N        1'b1
`define ODSM_PAD6            6'h00

`define ODSM_CH7_MUX_RNG     7:6
`define ODSM_PRESCALE_RNG    5:4
`define ODSM_STS1_RNG        3:2
`define ODSM_STS0_RNG        1:0
`define ODSM_PATH_PRE_BIT    0
`define ODSM_PATH_CH7_BIT    1
`define ODSM_PATH_RNG        1:0

`define ODSM_SRC_PLL         2'h0
`define ODSM_SRC_PRI         2'h2
`define ODSM_SRC_SEC         2'h3

`define ODSM_PRE_OFF         2'h0
`define ODSM_PRE_DIV4        2'h1
`define ODSM_PRE_DIV5        2'h2
`define ODSM_PRE_DIV4_M1     8'h03
`define ODSM_PRE_DIV5_M1     8'h04

`define ODSM_STS_DIVA        2'h0
`define ODSM_STS_DIVB        2'h1
`define ODSM_STS_NORMAL      2'h2
`define ODSM_STS_OFF         2'h3

`endif

/* core/odsm_pkg.sv */
// Types shared by the output divider and status mux block
package odsm_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } odsm_bus_t;

  typedef struct packed {
    logic pll1;
    logic pll2;
    logic pri_ref;
    logic sec_ref;
  } odsm_src_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } odsm_div_t;

  typedef struct packed {
    logic [1:0] ch7_mux;
    logic [7:0] ch7_div;
    logic [7:0] cmos_ctrl;
    logic [1:0] path_ctrl;
    logic [7:0] rdata;
    logic       ch7_byp;
    logic       tog_a;
    logic       tog_b;
    logic       sts0;
    logic       sts1;
    logic       sts0_oe_n;
    logic       sts1_oe_n;
  } odsm_state_t;

endpackage

/* core/odsm_pulse_div.sv */
// Divide a one-cycle tick stream by a programmable ratio
`timescale 1ns/10ps
`default_nettype none

`include "odsm_defines.svh"

module odsm_pulse_div (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // Control
  input  wire logic       i_run,
  input  wire logic [7:0] i_ratio_m1,
  // Ticks
  input  wire logic       i_tick,
  output logic            o_tick
);
  import odsm_pkg::*;

  odsm_div_t s_q;
  odsm_div_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!i_run) begin
      s_d.cnt = `ODSM_ZERO8;
    end else if (i_tick) begin
      // Compare with >= so a lowered ratio never waits a full wrap
      if (s_q.cnt >= i_ratio_m1) begin
        s_d.cnt  = `ODSM_ZERO8;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;

endmodule // odsm_pulse_div

`default_nettype wire

/* core/odsm_top.sv */
// Channel 7 output divider and status pin clock routing
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none

`include "odsm_defines.svh"

module odsm_top #(
  parameter logic [7:0] CMOS_A_RATIO_M1 = 8'h00,
  parameter logic [7:0] CMOS_B_RATIO_M1 = 8'h00
) (
  // Clock and reset
  input  wire logic             I_CLK,
  input  wire logic             I_NRST,
  // Register port
  input  wire odsm_pkg::odsm_bus_t I_BUS,
  output logic [7:0]            O_RDATA,
  // Clock source ticks
  input  wire odsm_pkg::odsm_src_t I_SRC,
  // Normal status signals
  input  wire logic             I_STATUS_PIN0_FUNC,
  input  wire logic             I_STATUS_PIN1_FUNC,
  // Channel 7 output tick
  output logic                  O_CH7_TICK,
  // Status pins
  output logic                  O_STATUS_PIN0,
  output logic                  O_STATUS_PIN0_OE_N,
  output logic                  O_STATUS_PIN1,
  output logic                  O_STATUS_PIN1_OE_N
);
  import odsm_pkg::*;

  odsm_state_t s_q;
  odsm_state_t s_d;

  logic       ch7_pll_tick;
  logic       ch7_from_pll;
  logic       ch7_div_tick;
  logic       pre_src_tick;
  logic       pre_run;
  logic [7:0] pre_ratio_m1;
  logic       pre_tick;
  logic       div_a_tick;
  logic       div_b_tick;
  logic [1:0] pre_sel;
  logic [1:0] pin0_out;
  logic [1:0] pin1_out;

  // Returns {level, oe_n} for one status pin
  function automatic logic [1:0] sts_route(input logic [1:0] sel,
                                           input logic       clk_a,
                                           input logic       clk_b,
                                           input logic       func);
    case (sel)
      `ODSM_STS_DIVA:   sts_route = {clk_a, 1'b0};
      `ODSM_STS_DIVB:   sts_route = {clk_b, 1'b0};
      `ODSM_STS_NORMAL: sts_route = {func, 1'b0};
      // Disabled pin is released and parked low
      default:          sts_route = {1'b0, 1'b1};
    endcase
  endfunction

  // Read-back image of one register; unmapped addresses read zero
  function automatic logic [7:0] reg_image(input logic [7:0]  addr,
                                           input odsm_state_t st);
    case (addr)
      `ODSM_ADDR_CH7_CTRL:  reg_image = {st.ch7_mux, `ODSM_PAD6};
      `ODSM_ADDR_CH7_DIV:   reg_image = st.ch7_div;
      `ODSM_ADDR_CMOS_CTRL: reg_image = st.cmos_ctrl;
      `ODSM_ADDR_PATH_CTRL: reg_image = {`ODSM_PAD6, st.path_ctrl};
      default:              reg_image = `ODSM_ZERO8;
    endcase
  endfunction

  // Synthesizer choice for channel 7 and the prescaler
  assign ch7_pll_tick = s_q.path_ctrl[`ODSM_PATH_CH7_BIT] ? I_SRC.pll2
                                                          : I_SRC.pll1;
  assign ch7_from_pll = (s_q.ch7_mux == `ODSM_SRC_PLL);
  assign pre_src_tick = s_q.path_ctrl[`ODSM_PATH_PRE_BIT] ? I_SRC.pll2
                                                          : I_SRC.pll1;
  assign pre_sel      = s_q.cmos_ctrl[`ODSM_PRESCALE_RNG];

  always_comb begin
    pre_run      = 1'b1;
    pre_ratio_m1 = `ODSM_PRE_DIV4_M1;
    case (pre_sel)
      `ODSM_PRE_DIV4: pre_ratio_m1 = `ODSM_PRE_DIV4_M1;
      `ODSM_PRE_DIV5: pre_ratio_m1 = `ODSM_PRE_DIV5_M1;
      // Off and reserved codes both stop the CMOS clock chain
      default:        pre_run      = 1'b0;
    endcase
  end

  // Channel 7 divider, held cleared while a reference feeds the channel
  odsm_pulse_div u_ch7_div (
    .i_clk      (I_CLK),
    .i_nrst     (I_NRST),
    .i_run      (ch7_from_pll),
    .i_ratio_m1 (s_q.ch7_div),
    .i_tick     (ch7_pll_tick),
    .o_tick     (ch7_div_tick)
  );

  // Prescaler and both CMOS dividers share one run gate, so a restart
  // always begins from a fully cleared chain
  odsm_pulse_div u_prescale (
    .i_clk      (I_CLK),
    .i_nrst     (I_NRST),
    .i_run      (pre_run),
    .i_ratio_m1 (pre_ratio_m1),
    .i_tick     (pre_src_tick),
    .o_tick     (pre_tick)
  );

  odsm_pulse_div u_cmos_a (
    .i_clk      (I_CLK),
    .i_nrst     (I_NRST),
    .i_run      (pre_run),
    .i_ratio_m1 (CMOS_A_RATIO_M1),
    .i_tick     (pre_tick),
    .o_tick     (div_a_tick)
  );

  odsm_pulse_div u_cmos_b (
    .i_clk      (I_CLK),
    .i_nrst     (I_NRST),
    .i_run      (pre_run),
    .i_ratio_m1 (CMOS_B_RATIO_M1),
    .i_tick     (pre_tick),
    .o_tick     (div_b_tick)
  );

  always_comb begin
    s_d       = s_q;
    s_d.rdata = `ODSM_ZERO8;

    // Register writes
    // Reserved CMOS control bits are stored so software reads them back
    if (I_BUS.wr) begin
      case (I_BUS.addr)
        `ODSM_ADDR_CH7_CTRL:  s_d.ch7_mux   = I_BUS.wdata[`ODSM_CH7_MUX_RNG];
        `ODSM_ADDR_CH7_DIV:   s_d.ch7_div   = I_BUS.wdata;
        `ODSM_ADDR_CMOS_CTRL: s_d.cmos_ctrl = I_BUS.wdata;
        `ODSM_ADDR_PATH_CTRL: s_d.path_ctrl = I_BUS.wdata[`ODSM_PATH_RNG];
        default:              s_d.ch7_div   = s_q.ch7_div;
      endcase
    end

    // Register reads, data valid the cycle after the strobe only
    if (I_BUS.rd) begin
      s_d.rdata = reg_image(I_BUS.addr, s_q);
    end

    // Reference bypass path, one flop to match the divider latency
    case (s_q.ch7_mux)
      `ODSM_SRC_PRI: s_d.ch7_byp = I_SRC.pri_ref;
      `ODSM_SRC_SEC: s_d.ch7_byp = I_SRC.sec_ref;
      // Synthesizer path uses the divider; reserved code stays silent
      default:       s_d.ch7_byp = 1'b0;
    endcase

    // Divider ticks become square clocks on the status pins
    if (!pre_run) begin
      s_d.tog_a = 1'b0;
      s_d.tog_b = 1'b0;
    end else begin
      s_d.tog_a = s_q.tog_a ^ div_a_tick;
      s_d.tog_b = s_q.tog_b ^ div_b_tick;
    end

    pin0_out      = sts_route(s_q.cmos_ctrl[`ODSM_STS0_RNG], s_q.tog_a,
                              s_q.tog_b, I_STATUS_PIN0_FUNC);
    pin1_out      = sts_route(s_q.cmos_ctrl[`ODSM_STS1_RNG], s_q.tog_a,
                              s_q.tog_b, I_STATUS_PIN1_FUNC);
    s_d.sts0      = pin0_out[1];
    s_d.sts0_oe_n = pin0_out[0];
    s_d.sts1      = pin1_out[1];
    s_d.sts1_oe_n = pin1_out[0];
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      s_q.ch7_mux   <= `ODSM_RST_CH7_MUX;
      s_q.ch7_div   <= `ODSM_RST_CH7_DIV;
      s_q.cmos_ctrl <= `ODSM_RST_CMOS_CTRL;
      s_q.path_ctrl <= `ODSM_RST_PATH_CTRL;
      s_q.rdata     <= `ODSM_ZERO8;
      s_q.ch7_byp   <= 1'b0;
      s_q.tog_a     <= 1'b0;
      s_q.tog_b     <= 1'b0;
      s_q.sts0      <= 1'b0;
      s_q.sts1      <= 1'b0;
      // Pins leave reset released; routing takes over one edge later
      s_q.sts0_oe_n <= `ODSM_RST_OE_N;
      s_q.sts1_oe_n <= `ODSM_RST_OE_N;
    end else begin
      s_q <= s_d;
    end
  end

  // Only the channel 7 select is combinational; it picks between two
  // flops so both source paths keep the same one-cycle latency
  assign O_RDATA            = s_q.rdata;
  assign O_CH7_TICK         = ch7_from_pll ? ch7_div_tick : s_q.ch7_byp;
  assign O_STATUS_PIN0      = s_q.sts0;
  assign O_STATUS_PIN0_OE_N = s_q.sts0_oe_n;
  assign O_STATUS_PIN1      = s_q.sts1;
  assign O_STATUS_PIN1_OE_N = s_q.sts1_oe_n;

endmodule // odsm_top

`default_nettype wire

/* verif/odsm_assertions.sv */
// Checker for the channel 7 divider and status pin routing
`timescale 1ns/10ps
`default_nettype none
module odsm_assertions (
  // Clock, reset, register port
  input wire logic                I_CLK,
  input wire logic                I_NRST,
  input wire odsm_pkg::odsm_bus_t I_BUS,
  input wire logic [7:0]          O_RDATA,
  // Sources and pins
  input wire odsm_pkg::odsm_src_t I_SRC,
  input wire logic                I_STATUS_PIN0_FUNC,
  input wire logic                I_STATUS_PIN1_FUNC,
  input wire logic                O_CH7_TICK,
  input wire logic                O_STATUS_PIN0,
  input wire logic                O_STATUS_PIN0_OE_N,
  input wire logic                O_STATUS_PIN1,
  input wire logic                O_STATUS_PIN1_OE_N
);
  import odsm_pkg::*;
  // Shadow copies, since the checker cannot see the registers
  logic [1:0] mux_q;
  logic [7:0] div_q;
  logic [7:0] cms_q;
  logic       pth_q;
  logic       syn;
  assign syn = pth_q ? I_SRC.pll2 : I_SRC.pll1;
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      mux_q <= 2'h0;
      div_q <= 8'h05;
      cms_q <= 8'h0a;
      pth_q <= 1'b0;
    end else if (I_BUS.wr) begin
      if (I_BUS.addr == 8'h2b) mux_q <= I_BUS.wdata[7:6];
      if (I_BUS.addr == 8'h2c) div_q <= I_BUS.wdata;
      if (I_BUS.addr == 8'h2d) cms_q <= I_BUS.wdata;
      if (I_BUS.addr == 8'h30) pth_q <= I_BUS.wdata[1];
    end
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  a_rdata_idle: assert property (!$past(I_BUS.rd) |-> O_RDATA == 8'h00)
    else $error("read data not idle");
  a_div_read: assert property (($past(I_BUS.rd) &&
    $past(I_BUS.addr) == 8'h2c) |-> O_RDATA == $past(div_q))
    else $error("divider readback");
  a_tick_cause: assert property (O_CH7_TICK |-> $past(I_SRC) != 4'h0)
    else $error("tick without source");
  a_ratio_one: assert property (($past(I_NRST) && mux_q == 2'h0 &&
    $past(mux_q) == 2'h0 && $past(div_q) == 8'h00 &&
    $past(pth_q) == pth_q) |-> O_CH7_TICK == $past(syn))
    else $error("ratio one not pass through");
  a_ref_bypass: assert property (($past(I_NRST) && mux_q == 2'h2 &&
    $past(mux_q) == 2'h2) |-> O_CH7_TICK == $past(I_SRC.pri_ref))
    else $error("reference not bypassed");
  a_pin0_normal: assert property (($past(I_NRST) &&
    $past(cms_q[1:0]) == 2'h2) |-> O_STATUS_PIN0 == $past(I_STATUS_PIN0_FUNC))
    else $error("pin0 status level");
  a_pin1_normal: assert property (($past(I_NRST) &&
    $past(cms_q[3:2]) == 2'h2) |-> O_STATUS_PIN1 == $past(I_STATUS_PIN1_FUNC))
    else $error("pin1 status level");
  a_pin0_off: assert property ($past(I_NRST) |->
    O_STATUS_PIN0_OE_N == ($past(cms_q[1:0]) == 2'h3))
    else $error("pin0 enable");
  a_pin1_off: assert property ($past(I_NRST) |->
    O_STATUS_PIN1_OE_N == ($past(cms_q[3:2]) == 2'h3))
    else $error("pin1 enable");
endmodule // odsm_assertions
bind odsm_top odsm_assertions u_chk (.I_CLK(I_CLK), .I_NRST(I_NRST),
  .I_BUS(I_BUS), .O_RDATA(O_RDATA), .I_SRC(I_SRC), .O_CH7_TICK(O_CH7_TICK),
  .I_STATUS_PIN0_FUNC(I_STATUS_PIN0_FUNC), .O_STATUS_PIN0(O_STATUS_PIN0),
  .I_STATUS_PIN1_FUNC(I_STATUS_PIN1_FUNC), .O_STATUS_PIN1(O_STATUS_PIN1),
  .O_STATUS_PIN0_OE_N(O_STATUS_PIN0_OE_N),
  .O_STATUS_PIN1_OE_N(O_STATUS_PIN1_OE_N));
`default_nettype wire

/* verif/odsm_tb_top.sv */
// Self-checking bench for the channel 7 divider and status routing
`timescale 1ns/10ps
`default_nettype none
module odsm_tb_top;
  import odsm_pkg::*;
  typedef struct packed {
    logic [7:0] mux;
    logic [7:0] div;
    logic [7:0] pth;
    logic [3:0] sel;
    int         n;
    int         e;
  } odsm_row_t;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  odsm_bus_t  b = '0;
  odsm_src_t  s = '0;
  logic       f0 = 1'b0;
  logic       f1 = 1'b0;
  logic [7:0] rdata;
  logic       tk, p0, p0e, p1, p1e;
  int         num_errors = 0;
  int         total_checks = 0;
  int         c7, c0, c1;
  // Source, ratio, path, tick lane, tick count, expected outputs
  odsm_row_t  rows [9] = '{
    '{8'h00, 8'h00, 8'h00, 4'h8, 10, 10},
    '{8'h00, 8'h02, 8'h00, 4'h8, 9, 3},
    '{8'h00, 8'hff, 8'h00, 4'h8, 512, 2},
    '{8'h00, 8'h01, 8'h02, 4'h4, 6, 3},
    '{8'h00, 8'h01, 8'h02, 4'h8, 6, 0},
    '{8'h00, 8'h01, 8'h00, 4'h2, 6, 0},
    '{8'h80, 8'h02, 8'h00, 4'h2, 6, 6},
    '{8'hc0, 8'h02, 8'h00, 4'h1, 6, 6},
    '{8'h40, 8'h00, 8'h00, 4'h8, 6, 0}};
  always #4 clk = ~clk;
  odsm_top #(.CMOS_A_RATIO_M1(8'h00), .CMOS_B_RATIO_M1(8'h01)) dut (
    .I_CLK(clk), .I_NRST(nrst), .I_BUS(b), .O_RDATA(rdata), .I_SRC(s),
    .I_STATUS_PIN0_FUNC(f0), .I_STATUS_PIN1_FUNC(f1), .O_CH7_TICK(tk),
    .O_STATUS_PIN0(p0), .O_STATUS_PIN0_OE_N(p0e), .O_STATUS_PIN1(p1),
    .O_STATUS_PIN1_OE_N(p1e));
  task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    b <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    b <= '0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    b <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    b <= '0;
    #1 chk("rdata", e, rdata);
  endtask
  // Ticks back to back, then idle long enough to drain the latency
  task automatic run(logic [3:0] sel, int n);
    logic q0, q1;
    c7 = 0;
    c0 = 0;
    c1 = 0;
    q0 = p0;
    q1 = p1;
    for (int i = 0; i < n + 8; i++) begin
      @(posedge clk);
      s <= (i < n) ? sel : 4'h0;
      #1;
      if (tk === 1'b1) c7++;
      if (p0 !== q0) c0++;
      if (p1 !== q1) c1++;
      q0 = p0;
      q1 = p1;
    end
  endtask
  // Prescaler off first so the prescaler and both CMOS dividers start cleared
  task automatic sts(logic [7:0] c, logic [7:0] pa, logic [3:0] sel,
                     logic [9:0] e0, logic [9:0] e1);
    wr(8'h2d, 8'h0a);
    wr(8'h30, pa);
    wr(8'h2d, c);
    run(sel, 40);
    chk("pin0 toggles", e0, c0[9:0]);
    chk("pin1 toggles", e1, c1[9:0]);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      wr(8'h2b, 8'h80);
      wr(8'h2c, rows[i].div);
      wr(8'h30, rows[i].pth);
      wr(8'h2b, rows[i].mux);
      run(rows[i].sel, rows[i].n);
      chk("ch7 ticks", rows[i].e[9:0], c7[9:0]);
    end
    sts(8'h14, 8'h00, 4'h8, 10'd10, 10'd5);
    sts(8'h24, 8'h00, 4'h8, 10'd8, 10'd4);
    sts(8'h11, 8'h00, 4'h8, 10'd5, 10'd10);
    sts(8'h34, 8'h00, 4'h8, 10'd0, 10'd0);
    sts(8'h14, 8'h01, 4'h4, 10'd10, 10'd5);
    sts(8'h14, 8'h01, 4'h8, 10'd0, 10'd0);
    wr(8'h2d, 8'h0a);
    f0 <= 1'b1;
    f1 <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("pin0", 10'h1, p0);
    chk("pin1", 10'h1, p1);
    chk("pin0 oe", 10'h0, p0e);
    wr(8'h2d, 8'h0f);
    repeat (2) @(posedge clk);
    #1 chk("pin0 off", 10'h0, p0);
    chk("pin1 oe", 10'h1, p1e);
    wr(8'h2c, 8'h03);
    rd(8'h2c, 8'h03);
    wr(8'h2b, 8'hff);
    rd(8'h2b, 8'hc0);
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h03);
    wr(8'h2d, 8'hff);
    rd(8'h2d, 8'hff);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    // Second reset in mid-run restores the documented defaults
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("pin0 oe in reset", 10'h1, p0e);
    chk("ch7 in reset", 10'h0, tk);
    nrst <= 1'b1;
    rd(8'h2c, 8'h05);
    rd(8'h2d, 8'h0a);
    rd(8'h2b, 8'h00);
    rd(8'h30, 8'h00);
    chk("pin0 oe reset", 10'h0, p0e);
    complete_run();
  end
endmodule // odsm_tb_top
`default_nettype wire
